// ==== rtl/seq_manager.sv ====
`timescale 1ns/10ps
module seq_manager
	import seq_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Radio datapath and timer
	input radio_evt_s evt,
	output radio_cmd_s cmd
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ARMED,
		ST_TX,
		ST_RX,
		ST_CCA,
		ST_ACK,
		ST_DONE
	} seq_state_e;

	seq_state_e state_reg;
	seq_state_e state_next;
	phy_ctrl_one_s ctrl_reg;
	phy_ctrl_one_s ctrl_next;
	phy_ctrl_one_s wr_ctrl;
	radio_cmd_s cmd_reg;
	radio_cmd_s cmd_next;
	logic [DATA_W-1:0] prdata_reg;
	logic [DATA_W-1:0] rdata_mux;
	logic [REJ_CNT_W-1:0] rej_cnt_reg;
	logic [REJ_CNT_W-1:0] rej_cnt_next;
	logic [7:0] ctrl_rd;
	logic [7:0] status_rd;

	// Reset image of the control fields; unimplemented bits dropped
	localparam phy_ctrl_one_s CTRL_RST = '{
		timer_start_enable: PHY_CTRL_ONE_RST[TMR_EN_BIT],
		expect_ack_after_tx: PHY_CTRL_ONE_RST[EXP_ACK_BIT],
		hw_ack_reply_enable: PHY_CTRL_ONE_RST[HW_ACK_BIT],
		sequence_select: PHY_CTRL_ONE_RST[SEL_LSB +: SEL_W]
	};

	// APB decode
	logic hit_ctrl;
	logic hit_status;
	logic hit_any;
	logic setup_rd;
	logic access;
	logic wr_ctrl_en;

	assign hit_ctrl = (paddr == PHY_CTRL_ONE_ADDR);
	assign hit_status = (paddr == SEQ_STATUS_ADDR);
	assign hit_any = hit_ctrl | hit_status;
	assign setup_rd = psel & ~penable & ~pwrite;
	assign access = psel & penable;
	assign wr_ctrl_en = access & pwrite & hit_ctrl;
	// Zero wait states; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = access & ~hit_any;
	assign prdata = prdata_reg;
	assign cmd = cmd_reg;

	// Decode of the written code and of the stored one
	seq_kind_s wr_kind;
	logic wr_valid;
	logic wr_idle;
	seq_kind_s cur_kind;
	logic cur_valid;
	logic cur_idle;

	seq_code_decode u_dec_wr (
		.code(pwdata[SEL_LSB +: SEL_W]),
		.kind(wr_kind),
		.valid(wr_valid),
		.is_idle(wr_idle)
	);

	seq_code_decode u_dec_cur (
		.code(ctrl_reg.sequence_select),
		.kind(cur_kind),
		.valid(cur_valid),
		.is_idle(cur_idle)
	);

	// Write classification
	logic st_idle;
	logic abort_wr;
	logic start_wr;
	logic sel_take;

	assign st_idle = (state_reg == ST_IDLE);
	// Idle code aborts from any state
	assign abort_wr = wr_ctrl_en & wr_idle; // [RQ8]
	// A sequence code is only taken when nothing is running or done;
	// software must pass through idle first
	assign start_wr = wr_ctrl_en & st_idle & wr_valid; // [RQ10] [RQ9]
	// Reserved codes leave the selector untouched
	assign sel_take = abort_wr | start_wr; // [RQ10] [RQ13]

	// Next control value: option bits always, selector gated
	assign wr_ctrl.timer_start_enable = pwdata[TMR_EN_BIT];
	assign wr_ctrl.expect_ack_after_tx = pwdata[EXP_ACK_BIT];
	assign wr_ctrl.hw_ack_reply_enable = pwdata[HW_ACK_BIT];
	assign wr_ctrl.sequence_select = sel_take ?
		pwdata[SEL_LSB +: SEL_W] : ctrl_reg.sequence_select;
	assign ctrl_next = wr_ctrl_en ? wr_ctrl : ctrl_reg;

	// Start gate: immediate or timer scheduled
	// Kept apart so an idle write can cancel a pending wait
	logic go;
	logic armed;

	seq_start_gate u_gate (
		.pclk(pclk),
		.presetn(presetn),
		.arm(start_wr),
		.timer_en(wr_ctrl.timer_start_enable),
		.timer_cmp(evt.timer_cmp),
		.cancel(abort_wr),
		.go(go),
		.waiting(armed)
	);

	// Effective options, gated by the running sequence
	logic exp_ack_eff;
	logic hw_ack_eff;
	logic frame_bad;
	logic send_ack;

	assign exp_ack_eff = ctrl_reg.expect_ack_after_tx & cur_kind.tr; // [RQ1]
	assign hw_ack_eff = ctrl_reg.hw_ack_reply_enable &
		(cur_kind.rx | cur_kind.tr); // [RQ4]
	// Non-ack frames only rejected when ack is expected
	assign frame_bad = exp_ack_eff & ~evt.rx_frame_is_ack; // [RQ2] [RQ3]
	assign send_ack = hw_ack_eff & evt.ack_conditions_ok; // [RQ5] [RQ6]

	// Kind that go launches: the freshly written one when immediate
	seq_kind_s go_kind;
	assign go_kind = start_wr ? wr_kind : cur_kind;

	// Which first command a launch issues; at most one is high
	logic launch_rx;
	logic launch_tx;
	logic launch_cca;

	assign launch_rx = go & go_kind.rx;
	assign launch_tx = go & (go_kind.tx | go_kind.tr);
	assign launch_cca = go & ~go_kind.rx & ~go_kind.tx & ~go_kind.tr;

	// Sequence state machine; abort has top priority
	always_comb begin
		state_next = state_reg;
		cmd_next = '0;
		cmd_next.rx_on = cmd_reg.rx_on;
		case (state_reg)
			ST_IDLE: begin
				// Timed start parks in armed until the compare
				if (start_wr && !go) begin
					state_next = ST_ARMED; // [RQ12]
				end
			end
			ST_ARMED: begin
				// Wait for the compare event
				// An idle write leaves through the abort below
			end
			ST_TX: begin
				if (evt.tx_done) begin
					if (cur_kind.tr) begin
						state_next = ST_RX;
						cmd_next.rx_on = 1'b1;
					end else begin
						state_next = ST_DONE;
						cmd_next.seq_done = 1'b1;
					end
				end
			end
			ST_RX: begin
				if (evt.rx_frame_done) begin
					if (frame_bad) begin
						// Keep listening for the ack
						cmd_next.frame_reject = 1'b1; // [RQ3]
					end else if (send_ack) begin
						cmd_next.frame_accept = 1'b1;
						cmd_next.rx_on = 1'b0;
						cmd_next.ack_tx_start = 1'b1; // [RQ6]
						state_next = ST_ACK;
					end else begin
						// Ends right after the frame
						cmd_next.frame_accept = 1'b1; // [RQ2]
						cmd_next.rx_on = 1'b0;
						cmd_next.seq_done = 1'b1; // [RQ5]
						state_next = ST_DONE;
					end
				end
			end
			ST_CCA: begin
				if (evt.cca_done) begin
					if (cur_kind.continuous_channel_assess_seq && !evt.cca_channel_idle) begin
						// Continuous: measure again until idle
						cmd_next.cca_start = 1'b1;
					end else begin
						cmd_next.seq_done = 1'b1;
						state_next = ST_DONE;
					end
				end
			end
			ST_ACK: begin
				if (evt.tx_done) begin
					cmd_next.seq_done = 1'b1;
					state_next = ST_DONE;
				end
			end
			ST_DONE: begin
				// Held until software writes idle
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		// Launch a sequence, immediate or timed
		if (launch_rx) begin
			state_next = ST_RX;
			cmd_next.rx_on = 1'b1;
		end
		if (launch_tx) begin
			state_next = ST_TX;
			cmd_next.tx_start = 1'b1;
		end
		if (launch_cca) begin
			state_next = ST_CCA;
			cmd_next.cca_start = 1'b1;
		end
		if (abort_wr) begin
			state_next = ST_IDLE; // [RQ8]
			cmd_next = '0;
		end
	end

	// Count of frames rejected while expecting an ack; saturates so a
	// flood of foreign frames cannot wrap it back to a small value
	logic rej_full;

	assign rej_full = (rej_cnt_reg == '1);
	assign rej_cnt_next = abort_wr ? '0 :
		(cmd_next.frame_reject && !rej_full) ?
		rej_cnt_reg + 1'b1 : rej_cnt_reg;

	// Status flags; busy only while the radio is being driven
	logic st_done;
	logic st_busy;
	logic [SEL_W-1:0] sel_shown;

	assign st_done = (state_reg == ST_DONE);
	assign st_busy = ~st_idle & (state_reg != ST_ARMED) & ~st_done;
	// A reserved code is never stored; idle shown if it ever were
	assign sel_shown = cur_valid ? ctrl_reg.sequence_select : SEQ_IDLE;

	// Read data; unmapped reads return zero beside the error
	assign ctrl_rd = {ctrl_reg.timer_start_enable, 2'h0,
		ctrl_reg.expect_ack_after_tx, ctrl_reg.hw_ack_reply_enable,
		ctrl_reg.sequence_select};
	assign status_rd = {2'h0, st_done, armed, st_busy, sel_shown};
	assign rdata_mux = hit_ctrl ? {24'h000000, ctrl_rd} :
		hit_status ? {16'h0000, rej_cnt_reg, status_rd} : 32'h00000000;

	// State, registers and commands
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			ctrl_reg <= CTRL_RST;
			cmd_reg <= '0;
			rej_cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			ctrl_reg <= ctrl_next;
			cmd_reg <= cmd_next;
			rej_cnt_reg <= rej_cnt_next;
		end
	end

	// Read data captured in setup so it stands through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= '0;
		end else if (setup_rd) begin
			prdata_reg <= rdata_mux;
		end
	end

endmodule : seq_manager

// ==== rtl/seq_ctrl_pkg.sv ====
// Operation
// RQ1: Expect-ack option only counts in transmit-then-receive
// RQ2: Option clear: any frame type accepted after transmit
// RQ3: Option set: only acknowledge accepted, others rejected
// RQ4: Hardware ack enable only in receive sequences
// RQ5: Ack disabled: no ack, sequence ends after frame
// RQ6: Ack enabled: send ack when conditions allow
// RQ7: Selector codes map to six sequences, two reserved
// RQ8: Writing idle aborts any sequence
// RQ9: Software writes idle between sequences
// RQ10: Non-idle selector writes ignored while sequence runs
// RQ11: Start immediately or at scheduled time
// RQ12: Timer enable low starts now, high waits compare
// RQ13: Reserved selector code does nothing, stays idle
package seq_ctrl_pkg;

	// Bus geometry
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	// Register indices; byte address is four times the index
	localparam logic [7:0] PHY_CTRL_ONE_IDX = 8'h03;
	localparam logic [7:0] SEQ_STATUS_IDX = 8'h20;
	localparam logic [ADDR_W-1:0] PHY_CTRL_ONE_ADDR =
		{2'h0, PHY_CTRL_ONE_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] SEQ_STATUS_ADDR =
		{2'h0, SEQ_STATUS_IDX, 2'h0};

	// Control register fields and reset value
	localparam int unsigned TMR_EN_BIT = 7;
	localparam int unsigned EXP_ACK_BIT = 4;
	localparam int unsigned HW_ACK_BIT = 3;
	localparam int unsigned SEL_LSB = 0;
	localparam int unsigned SEL_W = 3;
	localparam logic [7:0] PHY_CTRL_ONE_RST = 8'h00;

	// Status register fields
	localparam int unsigned STS_SEQ_LSB = 0;
	localparam int unsigned STS_BUSY_BIT = 3;
	localparam int unsigned STS_ARMED_BIT = 4;
	localparam int unsigned STS_DONE_BIT = 5;
	localparam int unsigned STS_REJ_LSB = 8;
	localparam int unsigned REJ_CNT_W = 8;

	// Sequence selector codes
	localparam logic [SEL_W-1:0] SEQ_IDLE = 3'h0;
	localparam logic [SEL_W-1:0] SEQ_RX = 3'h1;
	localparam logic [SEL_W-1:0] SEQ_TX = 3'h2;
	localparam logic [SEL_W-1:0] SEQ_CCA = 3'h3;
	localparam logic [SEL_W-1:0] SEQ_TR = 3'h4;
	localparam logic [SEL_W-1:0] SEQ_CONTINUOUS_CHANNEL_ASSESS_SEQ = 3'h5;

	typedef struct packed {
		logic timer_start_enable;
		logic expect_ack_after_tx;
		logic hw_ack_reply_enable;
		logic [SEL_W-1:0] sequence_select;
	} phy_ctrl_one_s;

	typedef struct packed {
		logic rx;
		logic tx;
		logic cca;
		logic tr;
		logic continuous_channel_assess_seq;
	} seq_kind_s;

	// Events from the radio datapath and timer, same clock
	typedef struct packed {
		logic timer_cmp;
		logic tx_done;
		logic rx_frame_done;
		logic rx_frame_is_ack;
		logic ack_conditions_ok;
		logic cca_done;
		logic cca_channel_idle;
	} radio_evt_s;

	// Commands to the radio datapath
	typedef struct packed {
		logic tx_start;
		logic rx_on;
		logic cca_start;
		logic ack_tx_start;
		logic seq_done;
		logic frame_accept;
		logic frame_reject;
	} radio_cmd_s;

endpackage : seq_ctrl_pkg

// ==== rtl/seq_code_decode.sv ====
`timescale 1ns/10ps
module seq_code_decode
	import seq_ctrl_pkg::*;
(
	// Selector code in
	input wire logic [SEL_W-1:0] code,
	// Decoded sequence
	output seq_kind_s kind,
	output logic valid,
	output logic is_idle
);

	// One-hot sequence decode; reserved codes give nothing
	assign kind.rx = (code == SEQ_RX); // [RQ7]
	assign kind.tx = (code == SEQ_TX); // [RQ7]
	assign kind.cca = (code == SEQ_CCA); // [RQ7]
	assign kind.tr = (code == SEQ_TR); // [RQ7]
	assign kind.continuous_channel_assess_seq = (code == SEQ_CONTINUOUS_CHANNEL_ASSESS_SEQ); // [RQ7]
	assign is_idle = (code == SEQ_IDLE);
	// Reserved codes are neither idle nor a sequence
	assign valid = |kind; // [RQ13]

endmodule : seq_code_decode

// ==== rtl/seq_start_gate.sv ====
`timescale 1ns/10ps
module seq_start_gate (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Requests
	input wire logic arm,
	input wire logic timer_en,
	input wire logic timer_cmp,
	input wire logic cancel,
	// Results
	output logic go,
	output logic waiting
);

	logic waiting_reg;
	logic waiting_next;

	// Immediate start, or held until the compare event
	assign go = (arm & ~timer_en) |
		(waiting_reg & timer_cmp & ~cancel); // [RQ11] [RQ12]
	assign waiting_next = cancel ? 1'b0 :
		(arm & timer_en) ? 1'b1 :
		(timer_cmp ? 1'b0 : waiting_reg); // [RQ12]
	assign waiting = waiting_reg;

	// Armed flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			waiting_reg <= 1'b0;
		end else begin
			waiting_reg <= waiting_next;
		end
	end

endmodule : seq_start_gate

// ==== sim/seq_manager_checker.sv ====
`timescale 1ns/10ps
module seq_manager_checker
	import seq_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Radio side
	input radio_evt_s evt,
	input radio_cmd_s cmd
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Control write decode; starts count only without timer wait
	wire wr = psel && penable && pwrite && paddr == PHY_CTRL_ONE_ADDR;
	wire [2:0] code = pwdata[2:0];
	wire now = wr && !pwdata[TMR_EN_BIT];
	wire fin = evt.tx_done || evt.rx_frame_done || evt.cca_done;
	wire ackev = evt.rx_frame_done && evt.ack_conditions_ok;

	idle_abort_a: assert property (wr && code == SEQ_IDLE
		|=> cmd == '0) else $error("command left on after idle");
	reserved_nop_a: assert property (wr && code > SEQ_CONTINUOUS_CHANNEL_ASSESS_SEQ
		&& !evt.cca_done && !evt.timer_cmp
		|=> !cmd.tx_start && !cmd.cca_start) else $error("reserved ran");
	tx_cause_a: assert property (cmd.tx_start |->
		$past(evt.timer_cmp || now && (code == SEQ_TX || code == SEQ_TR)))
		else $error("transmit start without cause");
	cca_cause_a: assert property (cmd.cca_start |->
		$past(evt.cca_done || evt.timer_cmp ||
		now && (code == SEQ_CCA || code == SEQ_CONTINUOUS_CHANNEL_ASSESS_SEQ)))
		else $error("assessment start without cause");
	ack_cause_a: assert property (cmd.ack_tx_start |->
		$past(ackev) || $past(ackev, 2)) else $error("stray ack");
	reject_cause_a: assert property (cmd.frame_reject |->
		$past(evt.rx_frame_done && !evt.rx_frame_is_ack))
		else $error("reject without non-ack frame");
	done_cause_a: assert property (cmd.seq_done |->
		$past(fin) || $past(fin, 2)) else $error("done without event");
	timer_wait_a: assert property (wr && pwdata[TMR_EN_BIT]
		&& code == SEQ_TX && !evt.timer_cmp |=> !cmd.tx_start)
		else $error("started before timer");

	// Main scenarios reached
	cover property (cmd.tx_start);
	cover property (cmd.ack_tx_start);
	cover property (cmd.frame_reject);
endmodule : seq_manager_checker

// ==== sim/test_autosequence_select_control.sv ====
`timescale 1ns/10ps
module test_autosequence_select_control import seq_ctrl_pkg::*;;
	typedef struct packed {
		logic [7:0] ctrl;
		radio_cmd_s first;
		radio_evt_s e1;
		radio_evt_s e2;
		radio_cmd_s mask;
		radio_cmd_s want;
	} row_s;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [DATA_W-1:0] prdata, rd;
	logic pready, pslverr, er;
	radio_evt_s evt = '0;
	radio_cmd_s cmd, seen;
	int errors = 0;
	int comparisons = 0;
	// Control byte, first command, events, watched and wanted commands
	row_s rows [11] = '{
		'{8'h02, 7'h40, 7'h20, 7'h00, 7'h0c, 7'h04},
		'{8'h03, 7'h10, 7'h02, 7'h00, 7'h14, 7'h04},
		'{8'h05, 7'h10, 7'h02, 7'h00, 7'h14, 7'h10},
		'{8'h05, 7'h10, 7'h03, 7'h00, 7'h14, 7'h04},
		'{8'h01, 7'h20, 7'h1c, 7'h00, 7'h0c, 7'h04},
		'{8'h09, 7'h20, 7'h1c, 7'h00, 7'h0c, 7'h08},
		'{8'h11, 7'h20, 7'h14, 7'h00, 7'h03, 7'h02},
		'{8'h14, 7'h40, 7'h20, 7'h10, 7'h03, 7'h01},
		'{8'h14, 7'h40, 7'h20, 7'h18, 7'h03, 7'h02},
		'{8'h04, 7'h40, 7'h20, 7'h10, 7'h03, 7'h02},
		'{8'h1a, 7'h40, 7'h20, 7'h00, 7'h0c, 7'h04}
	};

	always #2.5 pclk = ~pclk;

	seq_manager dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .evt(evt), .cmd(cmd));

	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("wrong value at %0t: %h not %h", $time, s, e);
		end
	endtask : chk

	// One APB transfer; slave latency is not assumed
	task apb(input logic w, input logic [ADDR_W-1:0] a,
		input logic [7:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk({31'h0, pready}, 32'h1);
		if (pready !== 1'b1)
			final_report;
	endtask : apb

	task wr(input logic [7:0] d);
		apb(1'b1, PHY_CTRL_ONE_ADDR, d);
		#1;
	endtask : wr

	task pulse(input radio_evt_s e);
		@(posedge pclk);
		evt <= e;
		@(posedge pclk);
		evt <= '0;
		#1;
	endtask : pulse

	// Bounded watch for any of the masked commands
	task wait_cmd(input radio_cmd_s m);
		int n;
		n = 0;
		while ((cmd & m) == '0 && n < 8) begin
			@(posedge pclk);
			#1;
			n++;
		end
		seen = cmd & m;
	endtask : wait_cmd

	task final_report;
		if (errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, PHY_CTRL_ONE_ADDR, 8'h00);
		chk(rd, {24'h0, PHY_CTRL_ONE_RST});
		foreach (rows[i]) begin
			wr(rows[i].ctrl);
			chk({25'h0, cmd}, {25'h0, rows[i].first});
			pulse(rows[i].e1);
			if (rows[i].e2 != '0)
				pulse(rows[i].e2);
			wait_cmd(rows[i].mask);
			chk({25'h0, seen}, {25'h0, rows[i].want});
			wr(8'h00);
			chk({25'h0, cmd}, 32'h0);
		end
		// Unimplemented bits 6 and 5 read back zero
		wr(8'hf8);
		apb(1'b0, PHY_CTRL_ONE_ADDR, 8'h00);
		chk(rd, 32'h98);
		wr(8'h00);
		apb(1'b0, 12'h010, 8'h00);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		for (int c = 6; c < 8; c++) begin
			wr(8'(c));
			chk({25'h0, cmd}, 32'h0);
			apb(1'b0, PHY_CTRL_ONE_ADDR, 8'h00);
			chk({29'h0, rd[2:0]}, 32'h0);
		end
		// Second selector write while transmit runs
		wr(8'h02);
		wr(8'h03);
		chk({25'h0, cmd}, 32'h0);
		apb(1'b0, PHY_CTRL_ONE_ADDR, 8'h00);
		chk({29'h0, rd[2:0]}, 32'h2);
		pulse(7'h20);
		wait_cmd(7'h04);
		chk({25'h0, seen}, 32'h4);
		apb(1'b0, SEQ_STATUS_ADDR, 8'h00);
		chk(rd, 32'h22);
		wr(8'h00);
		wr(8'h82);
		chk({25'h0, cmd}, 32'h0);
		apb(1'b0, SEQ_STATUS_ADDR, 8'h00);
		chk(rd, 32'h12);
		pulse(7'h40);
		chk({25'h0, cmd}, 32'h40);
		wr(8'h00);
		// Abort while armed, then a late compare
		wr(8'h82);
		wr(8'h80);
		pulse(7'h40);
		wait_cmd(7'h7f);
		chk({25'h0, seen}, 32'h0);
		// Two foreign frames while an ack is expected, then abort
		wr(8'h14);
		pulse(7'h20);
		pulse(7'h10);
		pulse(7'h10);
		chk({25'h0, cmd}, 32'h21);
		apb(1'b0, SEQ_STATUS_ADDR, 8'h00);
		chk(rd, 32'h20c);
		wr(8'h00);
		chk({25'h0, cmd}, 32'h0);
		apb(1'b0, SEQ_STATUS_ADDR, 8'h00);
		chk(rd, 32'h0);
		wr(8'h01);
		@(posedge pclk);
		presetn <= 1'b0;
		#1;
		chk({25'h0, cmd}, 32'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, PHY_CTRL_ONE_ADDR, 8'h00);
		chk(rd, 32'h0);
		final_report;
	end
endmodule : test_autosequence_select_control

bind seq_manager seq_manager_checker chk_i (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.evt, .cmd);
